/* File: src/tap_delay_pkg.sv */
// shared constants for the tapped delay line
package tap_delay_pkg;
  localparam int unsigned max_width = 65536;
  localparam int unsigned max_taps = 256;
  localparam int unsigned max_delay = 65536;
  localparam int unsigned def_width = 8;
  localparam int unsigned def_taps = 2;
  localparam int unsigned def_depth = 8;
  localparam int unsigned buf_entries = 2;
  localparam logic def_use_reset = 1'b1;
  localparam logic def_use_tdm = 1'b0;
endpackage : tap_delay_pkg

/* File: src/skid_buffer.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module skid_buffer #(
  parameter int unsigned width = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic [width-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [width-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  typedef struct packed {
    logic [1:0][width-1:0] mem;
    logic [1:0] count;
    logic has_word;
    logic has_room;
  } state_type;
  // empty buffer: no word held, room for two
  localparam state_type empty_state = '{
    mem: '0, count: 2'h0, has_word: 1'b0, has_room: 1'b1
  };
  state_type s_q;
  state_type s_d;
  logic push;
  logic pop;
  always_comb begin
    s_d = s_q;
    pop = s_q.count != 2'h0 && out_ready;
    push = in_valid && s_q.count != 2'h2;
    if (pop) begin
      s_d.mem[0] = s_q.mem[1];
    end
    if (push) begin
      if (s_q.count == 2'h0 || (s_q.count == 2'h1 && pop)) begin
        s_d.mem[0] = in_data;
      end else begin
        s_d.mem[1] = in_data;
      end
    end
    s_d.count = s_q.count + 2'(push) - 2'(pop);
    if (clear) begin
      s_d = '0;
    end
    // flags are registered so the outputs come from flip-flops
    s_d.has_word = s_d.count != 2'h0;
    s_d.has_room = s_d.count != 2'h2;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= empty_state;
    end else begin
      s_q <= s_d;
    end
  end
  assign in_ready = s_q.has_room;
  assign out_data = s_q.mem[0];
  assign out_valid = s_q.has_word;
endmodule : skid_buffer

/* File: src/tapped_delay.sv */
// multi-tap delay line with optional tap pairing and optional reset
//
// Functional notes
// - data width selectable from 1 to 65536
// - tap count 1 to 256, final included
// - tap zero lies nearest the input
// - each tap delays absolutely, 1 to 65536
// - adjacent taps may share one output path
// - reset disabled: reset_n input ignored, rst still clears
`timescale 1ns/100ps
module tapped_delay
  import tap_delay_pkg::*;
#(
  parameter int unsigned width = tap_delay_pkg::def_width,
  parameter int unsigned taps = tap_delay_pkg::def_taps,
  parameter int unsigned depth = tap_delay_pkg::def_depth,
  parameter int unsigned delays [taps] = '{default: 1},
  parameter logic [taps-1:0] tdm_pair = '0,
  parameter logic use_reset = tap_delay_pkg::def_use_reset
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic [width-1:0] data_in,
  output logic [taps-1:0][width-1:0] tap_out,
  output logic tdm_phase,
  output logic [width-1:0] last_data,
  output logic last_valid,
  input wire logic last_ready,
  output logic last_in_ready
);
  import tap_delay_pkg::*;

  // last tap of the list, the one whose word also feeds the buffer
  localparam int unsigned last_tap = taps - 1;

  // elaboration checks: a bad setting stops the build early

  if (width < 1) begin : g_bad_width_low
    $error("data width below one bit");
  end

  if (width > max_width) begin : g_bad_width_high
    $error("data width above the maximum");
  end

  if (taps < 1) begin : g_bad_taps_low
    $error("no taps configured");
  end

  if (taps > max_taps) begin : g_bad_taps_high
    $error("too many taps");
  end

  // the chain is at least one stage and no longer than the top delay
  if (depth < 1) begin : g_bad_depth_low
    $error("chain has no stages");
  end

  if (depth > max_delay) begin : g_bad_depth_high
    $error("chain longer than the maximum delay");
  end

  // the last tap has no partner, so it cannot open a pair
  if (tdm_pair[last_tap]) begin : g_bad_last_pair
    $error("last tap cannot be paired");
  end

  for (genvar g = 0; g < taps; g++) begin : g_tap_check
    if (delays[g] < 1) begin : g_bad_delay_low
      $error("tap delay below one cycle");
    end
    if (delays[g] > max_delay) begin : g_bad_delay_high
      $error("tap delay above the maximum");
    end
    // the output register gives one cycle, the chain the rest
    if (delays[g] > depth + 1) begin : g_short_chain
      $error("tap delay longer than the chain");
    end
    if (g + 1 < taps) begin : g_next
      if (delays[g] > delays[g+1]) begin : g_bad_order
        $error("taps out of order");
      end
      // overlapping pairs would fight over one output
      if (tdm_pair[g] && tdm_pair[g+1]) begin : g_bad_overlap
        $error("tap pairs overlap");
      end
    end
  end

  // whole state of the delay line in one record
  typedef struct packed {
    // chain of stages, stage 0 newest
    logic [depth-1:0][width-1:0] stage;
    // registered tap words, tap 0 nearest the input
    logic [taps-1:0][width-1:0] tap;
    // pairing phase, free running
    logic phase;
  } state_type;

  // state after any reset or clear: stages, taps and phase at zero
  localparam state_type clear_state = '0;

  state_type s_q;
  state_type s_d;

  // synchronous clear request, qualified by the reset option
  logic clr;

  // final tap as it leaves the buffer
  logic [width-1:0] buf_data;
  logic buf_valid;
  logic buf_in_ready;

  // ignore when disabled
  // with the option off the clear folds to a constant zero
  assign clr = use_reset && !reset_n;

  // timing: a word on data_in at edge k sits in stage 0 after edge k;
  // a tap of delay d shows it after edge k+d-1, one cycle later than
  // the stage it reads, because the tap itself is a register; a delay
  // of one therefore reads data_in straight, with no stage between
  always_comb begin
    logic [taps-1:0][width-1:0] pick;
    pick = '0;
    s_d = s_q;

    // shift the chain: stage 0 holds the input one cycle old
    s_d.stage[0] = data_in;
    for (int unsigned i = 1; i < depth; i++) begin
      s_d.stage[i] = s_q.stage[i-1];
    end

    // the pairing phase runs free and flips on every edge without a clear
    s_d.phase = ~s_q.phase;

    // absolute delay tap
    // delays count from the input, never from the tap before
    for (int unsigned t = 0; t < taps; t++) begin
      if (delays[t] <= 1) begin
        pick[t] = data_in;
      end else begin
        pick[t] = s_q.stage[delays[t]-2];
      end
    end

    // unpaired taps show their own word
    for (int unsigned t = 0; t < taps; t++) begin
      s_d.tap[t] = pick[t];
    end

    // tdm pair share
    // the lower tap of a pair loads its own word while the phase is
    // low and its partner's word while it is high; the partner's own
    // output stays at zero so nothing reads a stale copy
    for (int unsigned t = 0; t + 1 < taps; t++) begin
      if (tdm_pair[t]) begin
        if (s_q.phase) begin
          s_d.tap[t] = pick[t+1];
        end else begin
          s_d.tap[t] = pick[t];
        end
        s_d.tap[t+1] = '0;
      end
    end

    // synchronous clear
    // the clear also restarts the phase so pairs line up again
    if (clr) begin
      s_d = clear_state;
    end
  end

  // asynchronous reset loads constants only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= clear_state;
    end else begin
      s_q <= s_d;
    end
  end

  // every tap and the phase come straight from the state register
  assign tap_out = s_q.tap;
  assign tdm_phase = s_q.phase;

  // the final tap also streams through a buffer, but a stall by the
  // consumer still loses words; a word offered while the buffer is full
  // is lost to the buffer only, never to the taps
  skid_buffer #(
    .width(width)
  ) u_buf (
    .clock(clock),
    .rst(rst),
    .clear(clr),
    .in_data(s_q.tap[last_tap]),
    .in_valid(1'b1),
    .in_ready(buf_in_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(last_ready)
  );

  // the buffer drives these from its own register bits
  assign last_data = buf_data;
  assign last_valid = buf_valid;
  assign last_in_ready = buf_in_ready;

endmodule : tapped_delay

/* File: bench/tapped_delay_chk.sv */
// assertions for the tapped delay line
`timescale 1ns/100ps
module tapped_delay_chk #(
  parameter int width = 8,
  parameter int taps = 2,
  parameter logic use_reset = 1'b1,
  parameter logic tdm0 = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic [width-1:0] data_in,
  input wire logic [taps-1:0][width-1:0] tap_out,
  input wire logic tdm_phase,
  input wire logic [width-1:0] last_data,
  input wire logic last_valid,
  input wire logic last_ready,
  input wire logic last_in_ready
);
  // cycles since the last clear, saturating
  logic [2:0] age_q;
  always_ff @(posedge clock, posedge rst) begin
    if (rst) age_q <= 3'h0;
    else age_q <= !reset_n ? 3'h0 : age_q + 3'(age_q < 3'h7);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_tap_near: assert property (!tdm0 && age_q > 0
    |-> tap_out[0] == $past(data_in))
    else $error("near tap wrong");
  chk_tap_far: assert property (!tdm0 && age_q > 2
    |-> tap_out[1] == $past(data_in, 3))
    else $error("far tap wrong");
  chk_clear_taps: assert property (use_reset && !reset_n
    |=> tap_out == '0)
    else $error("taps not cleared");
  chk_tdm_zero: assert property (tdm0 |-> tap_out[1] == '0)
    else $error("paired partner not quiet");
  chk_phase_flip: assert property (reset_n |=> tdm_phase != $past(tdm_phase))
    else $error("phase stuck");
  chk_full_valid: assert property (!last_in_ready |-> last_valid)
    else $error("full but empty");
  chk_empty_ready: assert property (!last_valid |-> last_in_ready)
    else $error("empty but full");
  chk_stall_hold: assert property (last_valid && !last_ready && reset_n
    |=> last_valid && $stable(last_data))
    else $error("stalled word lost");
  cover property (!reset_n);
  cover property (!last_in_ready);
  cover property (last_valid && last_ready);
endmodule : tapped_delay_chk
bind tapped_delay tapped_delay_chk #(.width(width), .taps(taps),
  .use_reset(use_reset), .tdm0(tdm_pair[0])) chk (.*);

/* File: bench/delay_sink.sv */
// downstream consumer that stalls at random
`timescale 1ns/100ps
module delay_sink (
  input wire logic clock,
  output logic last_ready
);
  initial last_ready = 1'b0;
  // stalls often, so the buffer fills
  always @(negedge clock) last_ready <= 1'($random);
endmodule : delay_sink

/* File: bench/test_tapped_delay.sv */
// random stimulus bench for the tapped delay line
`timescale 1ns/100ps
module test_tapped_delay;
  logic clock = 0, rst = 1, reset_n = 1, last_ready;
  logic tdm_phase, last_valid, last_in_ready;
  logic [7:0] data_in = 8'h00, last_data;
  logic [1:0][7:0] tap_out;
  logic [3:0][7:0] h = '0;
  logic [3:0][7:0] g = '0;
  logic [1:0][7:0] tdm_tap;
  logic tdm_ph;
  logic ph = 1'b0;
  int num_errors = 0, comparisons = 0, seed = 32'h1f96;
  always #5 clock = ~clock;
  tapped_delay #(.taps(2), .delays('{1, 3})) uut (.*);
  delay_sink sink (.*);
  // paired taps with the reset option off
  tapped_delay #(.taps(2), .delays('{2, 4}), .tdm_pair(2'b01),
    .use_reset(1'b0)) uut_tdm (.clock(clock), .rst(rst),
    .reset_n(reset_n), .data_in(data_in), .tap_out(tdm_tap),
    .tdm_phase(tdm_ph), .last_data(), .last_valid(),
    .last_ready(last_ready), .last_in_ready());
  task check(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t got %h want %h", $time, g, e);
    end
  endtask : check
  task summarize;
    $display("%0d compares, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    #5000 num_errors++;
    summarize;
  end
  initial begin
    repeat (5) @(negedge clock);
    rst = 0;
    for (int i = 0; i < 300; i++) begin
      @(negedge clock);
      h = reset_n ? {h[2:0], data_in} : '0;
      check(tap_out[0], h[0]);
      check(tap_out[1], h[2]);
      g = {g[2:0], data_in};
      ph = ~ph;
      check(tdm_ph, ph);
      check(tdm_tap[0], ph ? g[1] : g[3]);
      check(tdm_tap[1], 8'h00);
      reset_n = (i % 97 != 50);
      data_in = 8'($random(seed));
    end
    $display("random run done");
    summarize;
  end
endmodule : test_tapped_delay
